// ===== cid_addr_gen.sv
// Effective address generator for the operand addressing modes.
`timescale 1ns/1ns
module cid_addr_gen
  import cid_pkg::*;
(
  // Mode and trailing operand bytes.
  input  wire cid_mode_e   md,
  input  wire logic [15:0] ob,
  // Base registers.
  input  wire logic [15:0] hx,
  input  wire logic [15:0] sp,
  // Result.
  output logic      [15:0] ea
);

  // Address forms; bytes fetched first sit in ob[15:8].
  always_comb begin
    unique case (md)
      M_DIR:  ea = {8'h00, ob[7:0]};
      M_FULL: ea = ob;
      M_IX:   ea = hx;
      M_IXB:  ea = hx + {8'h00, ob[7:0]};
      M_IXW:  ea = hx + ob;
      M_SPB:  ea = sp + {8'h00, ob[7:0]};
      M_SPW:  ea = sp + ob;
      M_IXP:  ea = hx;
      M_IX1P: ea = hx + {8'h00, ob[15:8]};
      M_D2D:  ea = {8'h00, ob[15:8]};
      M_DIXP: ea = {8'h00, ob[7:0]};
      M_IXPD: ea = hx;
      M_BRB:  ea = {8'h00, ob[15:8]};
      default: ea = {8'h00, ob[7:0]};
    endcase
  end

endmodule // cid_addr_gen

// ===== cid_cfg.svh
// Opcode, flag and timing constants for the instruction decode slice.
`ifndef CID_CFG_SVH
`define CID_CFG_SVH

// Opcodes handled by this slice.
`define CID_OP_PREFIX    8'h9e
`define CID_OP_TRAP      8'h83
`define CID_OP_A2F       8'h84
`define CID_OP_F2A       8'h85
`define CID_OP_A2X       8'h97
`define CID_OP_X2A       8'h9f
`define CID_OP_S2X       8'h95
`define CID_OP_X2S       8'h94
`define CID_OP_WAIT      8'h8f
`define CID_OP_TSTA      8'h4d
`define CID_OP_TSTX      8'h5d
`define CID_OP_CBEQ_IX1P 8'h61
`define CID_OP_CBEQ_IXP  8'h71

// Condition flag bit positions.
`define CID_FLG_V 7
`define CID_FLG_H 4
`define CID_FLG_I 3
`define CID_FLG_N 2
`define CID_FLG_Z 1
`define CID_FLG_C 0

// Reset values and fixed bits.
`define CID_FLG_FIXED 8'h60
`define CID_FLG_RST   8'h68
`define CID_SP_RST    16'h00ff
`define CID_HX_RST    16'h0000

// Trap sequence timing.
`define CID_TRAP_PUSHES 3'h5
`define CID_TRAP_LAST   3'h7
`define CID_TRAP_CYCLES 9

`endif

// ===== cid_insn_decode.sv
// Decode and execute sequencer for the trap, transfer, test, wait and addressing slice.
`timescale 1ns/1ns
`include "cid_cfg.svh"

// Operation
// - The trap opcode advances PC, pushes PC low, PC high, index low, accumulator and flags, sets the mask, loads the vector, in 9 cycles.
// - Test compares accumulator, index low or memory with zero, sets N and Z, clears V, keeps C, inherent forms in one cycle.
// - Wait clears the interrupt mask and halts the core until an interrupt, issuing in one cycle.
// - Stack-relative mode adds one unsigned trailing byte to the stack pointer.
// - Stack-relative mode also exists with a two-byte offset.
// - Indexed mode adds one trailing offset byte to the 16-bit index pair.
// - Indexed mode adds a two-byte offset, high byte first, to the index pair.
// - Indexed post-increment uses the index pair as the location and then increments it.
// - Offset post-increment adds one byte to the index pair for the location, then increments the pair.
// - Move copies an immediate byte to a direct-page location.
// - Move copies one direct-page location to another, both from trailing bytes.
// - Move reads a direct-page location, writes it at the index pair, then increments the pair.
// - Move reads at the index pair, increments the pair, and writes to a direct-page location.
// - Extended forms fetch a two-byte location, most significant byte first.
// - Bit-test-and-branch fetches a direct-page byte and then a signed displacement for the PC.
module cid_insn_decode
  import cid_pkg::*;
#(
  parameter logic [15:0] TRAP_VEC = 16'hfff0,
  parameter logic [15:0] RESET_PC = 16'h0000
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Memory bus; read data answers the address in the same cycle.
  input  wire logic [7:0]  mem_rdata,
  output cid_mem_req_s     mem_req,
  // Interrupt pin and halt status.
  input  wire logic        irq_req,
  output logic             core_halted,
  // Register view.
  output cid_regs_s        cpu_regs
);

  cid_state_e  st_reg, st_next;
  cid_mode_e   md_reg, md_next, dmd;
  cid_cls_e    cls_reg, cls_next, dcls;
  logic [15:0] pc_reg, pc_next, sp_reg, sp_next, hx_reg, hx_next;
  logic [15:0] ob_reg, ob_next, ea, br_pc;
  logic [7:0]  a_reg, a_next, flg_reg, flg_next, op_reg, op_next;
  logic [7:0]  dat_reg, dat_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        pfx_reg, pfx_next, dec_go, bit_set;
  logic [2:0]  irq_sync;
  logic        irq_seen;

  // Mode of an opcode; the prefix turns indexed rows 6, D and E into stack rows.
  function automatic cid_mode_e f_mode(input logic p, input logic [7:0] o);
    f_mode = M_INH;
    case (o[7:4])
      4'h0:       f_mode = M_BRB;
      4'h3, 4'hb: f_mode = M_DIR;
      4'h4:       f_mode = (o[3:0] == 4'he) ? M_D2D : M_INH;
      4'h5:       f_mode = (o[3:0] == 4'he) ? M_DIXP : M_INH;
      4'h6:       f_mode = (o[3:0] == 4'he) ? M_I2D : (o[3:0] == 4'h1) ? M_IX1P : (p ? M_SPB : M_IXB);
      4'h7:       f_mode = (o[3:0] == 4'he) ? M_IXPD : (o[3:0] == 4'h1) ? M_IXP : M_IX;
      4'hc:       f_mode = M_FULL;
      4'hd:       f_mode = p ? M_SPW : M_IXW;
      4'he:       f_mode = p ? M_SPB : M_IXB;
      4'hf:       f_mode = M_IX;
      default:    f_mode = M_INH;
    endcase
  endfunction

  // Operation class of an opcode; prefixed forms exist only in rows 6, D and E.
  function automatic cid_cls_e f_cls(input logic p, input logic [7:0] o);
    logic [3:0] h;
    h = o[7:4];
    f_cls = C_NONE;
    if (p && !(h == 4'h6 || h == 4'hd || h == 4'he))
      f_cls = C_NONE;
    else if (h == 4'h0 && !p)
      f_cls = C_BRB;
    else if (o[3:0] == 4'hd && (h == 4'h3 || h == 4'h6 || h == 4'h7))
      f_cls = C_TEST;
    else if ((o == `CID_OP_CBEQ_IX1P || o == `CID_OP_CBEQ_IXP) && !p)
      f_cls = C_CBEQ;
    else if (o[3:0] == 4'he && h >= 4'h4 && h <= 4'h7 && !p)
      f_cls = C_MOV;
    else if (h >= 4'hb && o[3:0] == 4'h6)
      f_cls = C_LDA;
    else if (h >= 4'hb && o[3:0] == 4'h7)
      f_cls = C_STA;
  endfunction

  // Trailing operand bytes per mode.
  function automatic logic [1:0] f_nb(input cid_mode_e m);
    unique case (m)
      M_INH, M_IX:                                 f_nb = 2'd0;
      M_DIR, M_IXB, M_SPB, M_IXP, M_DIXP, M_IXPD:  f_nb = 2'd1;
      default:                                     f_nb = 2'd2;
    endcase
  endfunction

  // Negative and zero from a value, overflow cleared, carry kept.
  function automatic logic [7:0] f_nz(input logic [7:0] c, input logic [7:0] v);
    f_nz = c;
    f_nz[`CID_FLG_V] = 1'b0;
    f_nz[`CID_FLG_N] = v[7];
    f_nz[`CID_FLG_Z] = (v == 8'h00);
  endfunction

  cid_addr_gen u_addr_gen (
    .md (md_reg),
    .ob (ob_reg),
    .hx (hx_reg),
    .sp (sp_reg),
    .ea (ea)
  );

  // The interrupt pin is foreign; it counts once the last two stages are both high.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_sync <= 3'h0;
    end else begin
      irq_sync <= {irq_sync[1:0], irq_req};
    end
  end
  assign irq_seen = irq_sync[1] & irq_sync[2];

  // Decode of the byte on the bus during fetch; a lone prefix byte only arms the prefix.
  assign dec_go  = (st_reg == S_FETCH) && !(mem_rdata == `CID_OP_PREFIX && !pfx_reg);
  assign dmd     = f_mode(pfx_reg, mem_rdata);
  assign dcls    = f_cls(pfx_reg, mem_rdata);
  assign br_pc   = pc_reg + {{8{ob_reg[7]}}, ob_reg[7:0]};
  assign bit_set = mem_rdata[op_reg[3:1]];

  // Bus drive follows the current state so an address never lags its cycle.
  always_comb begin
    mem_req = '0;
    unique case (st_reg)
      S_FETCH, S_OPND: begin
        mem_req.addr = pc_reg;
        mem_req.rd   = 1'b1;
      end
      S_RD: begin
        mem_req.addr = ea;
        mem_req.rd   = 1'b1;
      end
      S_WR: begin
        mem_req.wr    = 1'b1;
        mem_req.wdata = dat_reg;
        if (cls_reg == C_MOV && md_reg != M_DIXP)
          mem_req.addr = {8'h00, ob_reg[7:0]};
        else
          mem_req.addr = (md_reg == M_DIXP) ? hx_reg : ea;
      end
      S_TRAP: begin
        mem_req.addr = sp_reg;
        mem_req.wr   = (cnt_reg < `CID_TRAP_PUSHES);
        unique case (cnt_reg)
          3'd0:    mem_req.wdata = pc_reg[7:0];
          3'd1:    mem_req.wdata = pc_reg[15:8];
          3'd2:    mem_req.wdata = hx_reg[7:0];
          3'd3:    mem_req.wdata = a_reg;
          3'd4:    mem_req.wdata = flg_reg;
          default: mem_req.wdata = 8'h00;
        endcase
        if (cnt_reg == 3'd5 || cnt_reg == 3'd6) begin
          mem_req.addr = (cnt_reg == 3'd5) ? TRAP_VEC : TRAP_VEC + 16'h0001;
          mem_req.rd   = 1'b1;
        end
      end
      default: mem_req = '0;
    endcase
  end

  // Next values of the whole sequencer and register set.
  always_comb begin
    st_next  = st_reg;
    md_next  = md_reg;
    cls_next = cls_reg;
    pc_next  = pc_reg;
    sp_next  = sp_reg;
    hx_next  = hx_reg;
    a_next   = a_reg;
    flg_next = flg_reg;
    op_next  = op_reg;
    ob_next  = ob_reg;
    dat_next = dat_reg;
    cnt_next = cnt_reg;
    pfx_next = pfx_reg;
    unique case (st_reg)
      S_FETCH: begin
        pc_next = pc_reg + 16'h0001;
        if (!dec_go) begin
          pfx_next = 1'b1;
        end else begin
          pfx_next = 1'b0;
          op_next  = mem_rdata;
          md_next  = dmd;
          cls_next = dcls;
          ob_next  = 16'h0000;
          if (pfx_reg) begin
            if (dcls != C_NONE)
              st_next = S_OPND;
          end else if (mem_rdata == `CID_OP_TRAP) begin
            st_next  = S_TRAP;
            cnt_next = 3'd0;
          end else if (mem_rdata == `CID_OP_A2F) begin
            flg_next = a_reg | `CID_FLG_FIXED;
            st_next  = S_IDLE;
          end else if (mem_rdata == `CID_OP_F2A) begin
            a_next = flg_reg;
          end else if (mem_rdata == `CID_OP_A2X) begin
            hx_next[7:0] = a_reg;
          end else if (mem_rdata == `CID_OP_X2A) begin
            a_next = hx_reg[7:0];
          end else if (mem_rdata == `CID_OP_S2X) begin
            hx_next = sp_reg + 16'h0001;
            st_next = S_IDLE;
          end else if (mem_rdata == `CID_OP_X2S) begin
            sp_next = hx_reg - 16'h0001;
            st_next = S_IDLE;
          end else if (mem_rdata == `CID_OP_TSTA) begin
            flg_next = f_nz(flg_reg, a_reg);
          end else if (mem_rdata == `CID_OP_TSTX) begin
            flg_next = f_nz(flg_reg, hx_reg[7:0]);
          end else if (mem_rdata == `CID_OP_WAIT) begin
            flg_next[`CID_FLG_I] = 1'b0;
            st_next = S_WAIT;
          end else if (dcls != C_NONE) begin
            if (f_nb(dmd) != 2'd0) begin
              st_next = S_OPND;
            end else if (dcls == C_STA) begin
              dat_next = a_reg;
              st_next  = S_WR;
            end else begin
              st_next = S_RD;
            end
          end
          cnt_next = (f_nb(dmd) == 2'd2) ? 3'd1 : 3'd0;
          if (mem_rdata == `CID_OP_TRAP && !pfx_reg)
            cnt_next = 3'd0;
        end
      end
      S_OPND: begin
        // Bytes shift in from the low end, so the first fetched lands high.
        ob_next  = {ob_reg[7:0], mem_rdata};
        pc_next  = pc_reg + 16'h0001;
        cnt_next = cnt_reg - 3'd1;
        if (cnt_reg == 3'd0) begin
          if (cls_reg == C_MOV && md_reg == M_I2D) begin
            dat_next = ob_reg[7:0];
            st_next  = S_WR;
          end else if (cls_reg == C_STA) begin
            dat_next = a_reg;
            st_next  = S_WR;
          end else begin
            st_next = S_RD;
          end
        end
      end
      S_RD: begin
        st_next = S_FETCH;
        unique case (cls_reg)
          C_TEST: flg_next = f_nz(flg_reg, mem_rdata);
          C_LDA:  begin
            a_next   = mem_rdata;
            flg_next = f_nz(flg_reg, mem_rdata);
          end
          C_CBEQ: begin
            hx_next = hx_reg + 16'h0001;
            if (a_reg == mem_rdata)
              pc_next = br_pc;
          end
          C_BRB:  begin
            flg_next[`CID_FLG_C] = bit_set;
            if (bit_set != op_reg[0])
              pc_next = br_pc;
          end
          C_MOV:  begin
            dat_next = mem_rdata;
            st_next  = S_WR;
            if (md_reg == M_IXPD)
              hx_next = hx_reg + 16'h0001;
          end
          default: st_next = S_FETCH;
        endcase
      end
      S_WR: begin
        st_next  = S_FETCH;
        flg_next = f_nz(flg_reg, dat_reg);
        if (md_reg == M_DIXP)
          hx_next = hx_reg + 16'h0001;
      end
      S_TRAP: begin
        // Five pushes, two vector reads, one settling cycle.
        cnt_next = cnt_reg + 3'd1;
        if (cnt_reg < `CID_TRAP_PUSHES)
          sp_next = sp_reg - 16'h0001;
        if (cnt_reg == 3'd4)
          flg_next[`CID_FLG_I] = 1'b1;
        if (cnt_reg == 3'd5)
          pc_next[15:8] = mem_rdata;
        if (cnt_reg == 3'd6)
          pc_next[7:0] = mem_rdata;
        if (cnt_reg == `CID_TRAP_LAST)
          st_next = S_FETCH;
      end
      S_IDLE: st_next = S_FETCH;
      S_WAIT: begin
        // The core is held by staying here; fetch resumes at the next opcode once the interrupt is seen.
        if (irq_seen)
          st_next = S_FETCH;
      end
      default: st_next = S_FETCH;
    endcase
  end

  // Register everything.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg  <= S_FETCH;
      md_reg  <= M_INH;
      cls_reg <= C_NONE;
      pc_reg  <= RESET_PC;
      sp_reg  <= `CID_SP_RST;
      hx_reg  <= `CID_HX_RST;
      a_reg   <= 8'h00;
      flg_reg <= `CID_FLG_RST;
      op_reg  <= 8'h00;
      ob_reg  <= 16'h0000;
      dat_reg <= 8'h00;
      cnt_reg <= 3'h0;
      pfx_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      md_reg  <= md_next;
      cls_reg <= cls_next;
      pc_reg  <= pc_next;
      sp_reg  <= sp_next;
      hx_reg  <= hx_next;
      a_reg   <= a_next;
      flg_reg <= flg_next;
      op_reg  <= op_next;
      ob_reg  <= ob_next;
      dat_reg <= dat_next;
      cnt_reg <= cnt_next;
      pfx_reg <= pfx_next;
    end
  end

  assign core_halted = (st_reg == S_WAIT);
  assign cpu_regs    = '{pc: pc_reg, sp: sp_reg, hx: hx_reg, a: a_reg, flg: flg_reg};

  // Checks on the sequencer.
  a_trap_nine_cycles: assert property (@(posedge clk_sys) disable iff (!resetn)
    dec_go && !pfx_reg && mem_rdata == `CID_OP_TRAP |=> (st_reg == S_TRAP) [*8] ##1 st_reg == S_FETCH)
    else $error("trap sequence length wrong");
  a_trap_mask_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_reg == S_TRAP && cnt_reg == 3'd4 |=> flg_reg[`CID_FLG_I] && sp_reg == $past(sp_reg) - 16'h0001)
    else $error("trap did not set mask");
  a_test_inh_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
    dec_go && !pfx_reg && mem_rdata == `CID_OP_TSTA |=> st_reg == S_FETCH && !flg_reg[`CID_FLG_V]
      && flg_reg[`CID_FLG_C] == $past(flg_reg[`CID_FLG_C]) && flg_reg[`CID_FLG_Z] == ($past(a_reg) == 8'h00))
    else $error("test flags wrong");
  a_wait_halt: assert property (@(posedge clk_sys) disable iff (!resetn)
    dec_go && !pfx_reg && mem_rdata == `CID_OP_WAIT |=> core_halted && !flg_reg[`CID_FLG_I])
    else $error("wait did not halt");
  a_sp_rel_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_reg == S_RD && md_reg == M_SPB |-> mem_req.addr == sp_reg + {8'h00, ob_reg[7:0]})
    else $error("stack relative address wrong");
  a_full_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_reg == S_RD && md_reg == M_FULL |-> mem_req.addr == ob_reg)
    else $error("extended address wrong");
  a_postinc_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_reg == S_RD && cls_reg == C_CBEQ |=> hx_reg == $past(hx_reg) + 16'h0001)
    else $error("post increment missing");
  a_s2x_plus_one: assert property (@(posedge clk_sys) disable iff (!resetn)
    dec_go && !pfx_reg && mem_rdata == `CID_OP_S2X |=> hx_reg == $past(sp_reg) + 16'h0001 ##1 st_reg == S_FETCH)
    else $error("stack to index wrong");
  a_x2s_minus_one: assert property (@(posedge clk_sys) disable iff (!resetn)
    dec_go && !pfx_reg && mem_rdata == `CID_OP_X2S |=> sp_reg == $past(hx_reg) - 16'h0001)
    else $error("index to stack wrong");

endmodule // cid_insn_decode

// ===== cid_mem_model.sv
// Zero-latency program and data memory that faces the decode slice.
`timescale 1ns/1ns
module cid_mem_model
  import cid_pkg::*;
(
  // Clock.
  input  wire logic         clk_sys,
  // Bus from the core.
  input  wire cid_mem_req_s req,
  output logic        [7:0] rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;

  // Reads answer in the same cycle; an idle bus shows the inverse of the previous cycle's rdata, so a second idle cycle shows the last read byte again.
  always_comb begin
    rdata = req.rd ? mem[req.addr] : ~last_reg;
  end

  // Writes land at the edge that ends the write cycle; the bench also preloads this array directly.
  always @(posedge clk_sys) begin
    if (req.wr) begin
      mem[req.addr] <= req.wdata;
    end
    last_reg <= rdata;
  end
endmodule // cid_mem_model

// ===== cid_pkg.sv
// Types shared by the instruction decode slice.
package cid_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [6:0] {
    S_FETCH = 7'h01,
    S_OPND  = 7'h02,
    S_RD    = 7'h04,
    S_WR    = 7'h08,
    S_TRAP  = 7'h10,
    S_IDLE  = 7'h20,
    S_WAIT  = 7'h40
  } cid_state_e;

  // Operand addressing modes.
  typedef enum logic [3:0] {
    M_INH, M_DIR, M_FULL, M_IX, M_IXB, M_IXW, M_SPB, M_SPW,
    M_IXP, M_IX1P, M_I2D, M_D2D, M_DIXP, M_IXPD, M_BRB
  } cid_mode_e;

  // Operation classes executed with a memory operand.
  typedef enum logic [2:0] {
    C_NONE, C_TEST, C_LDA, C_STA, C_MOV, C_CBEQ, C_BRB
  } cid_cls_e;

  // One memory bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } cid_mem_req_s;

  // Programmer-visible registers.
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [7:0]  a;
    logic [7:0]  flg;
  } cid_regs_s;

endpackage

// ===== tb_cpu_insn_decode_tail.sv
// Self-checking bench for the trap, transfer, test, wait and addressing slice.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_cpu_insn_decode_tail
  import cid_pkg::*;
;
  logic         clk_sys;
  logic         resetn;
  logic         irq_req;
  logic         core_halted;
  logic [7:0]   mem_rdata;
  cid_mem_req_s mem_req;
  cid_regs_s    regs;
  int           fail_count;
  int           n_tests;

  // Core under test and its memory.
  cid_insn_decode #(.TRAP_VEC(16'hfff0), .RESET_PC(16'h0000)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .irq_req(irq_req), .core_halted(core_halted), .cpu_regs(regs));
  cid_mem_model u_mem (.clk_sys(clk_sys), .req(mem_req), .rdata(mem_rdata));

  // Clock of 100 ns period.
  always #50 clk_sys = ~clk_sys;

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Places up to four code bytes at the current pc and runs the documented cycle count.
  task automatic exec(input logic [31:0] code, input int cyc);
    logic [15:0] p;
    p = regs.pc;
    for (int i = 0; i < 4; i++) u_mem.mem[p + 16'(i)] = code[31 - 8 * i -: 8];
    repeat (cyc) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Transfers between accumulator, flags, index pair and stack pointer.
  task automatic s_xfer();
    u_mem.mem[16'h0090] = 8'h81;
    exec(32'hc600_909d, 4);
    `CHK("a full location", 8'h81, regs.a)
    exec(32'h849d_9d9d, 2);
    `CHK("flags from a", 8'he1, regs.flg)
    exec(32'h859d_9d9d, 1);
    `CHK("a from flags", {8'he1, 8'he1}, {regs.a, regs.flg})
    exec(32'h959d_9d9d, 2);
    `CHK("hx from sp", 16'h0100, regs.hx)
    exec(32'h979d_9d9d, 1);
    `CHK("hx from a", 16'h01e1, regs.hx)
    exec(32'h949d_9d9d, 2);
    `CHK("sp from hx", 16'h01e0, regs.sp)
  endtask

  // Test against zero keeps carry and clears overflow.
  task automatic s_test();
    u_mem.mem[16'h0091] = 8'h00;
    u_mem.mem[16'h01f0] = 8'h00;
    exec(32'h4d9d_9d9d, 1);
    `CHK("flags test a", 8'h65, regs.flg)
    exec(32'hc600_919d, 4);
    exec(32'h5d9d_9d9d, 1);
    `CHK("flags test x", 8'h65, regs.flg)
    exec(32'h9f9d_9d9d, 1);
    `CHK("a from x", {8'he1, 8'h65}, {regs.a, regs.flg})
    exec(32'h9e6d_109d, 4);
    `CHK("flags test stack", 8'h63, regs.flg)
  endtask

  // Indexed, stack-relative and post-increment operand locations.
  task automatic s_modes();
    logic [15:0] p;
    u_mem.mem[16'h01e6] = 8'h11;
    u_mem.mem[16'h02e3] = 8'h12;
    u_mem.mem[16'h01e3] = 8'h13;
    u_mem.mem[16'h02e0] = 8'h14;
    u_mem.mem[16'h01e1] = 8'h14;
    u_mem.mem[16'h01e4] = 8'h55;
    exec(32'he605_9d9d, 3);
    `CHK("a index byte", 8'h11, regs.a)
    exec(32'hd601_029d, 4);
    `CHK("a index word", 8'h12, regs.a)
    exec(32'h9ee6_039d, 4);
    `CHK("a stack byte", 8'h13, regs.a)
    exec(32'h9ed6_0100, 5);
    `CHK("a stack word", 8'h14, regs.a)
    p = regs.pc;
    exec(32'h7104_9d9d, 3);
    `CHK("postinc pc hx", {p + 16'h0006, 16'h01e2}, {regs.pc, regs.hx})
    p = regs.pc;
    exec(32'h6102_fc9d, 4);
    `CHK("offset postinc pc hx", {p + 16'h0003, 16'h01e3}, {regs.pc, regs.hx})
  endtask

  // The four move forms.
  task automatic s_move();
    exec(32'h6e5a_809d, 4);
    `CHK("move immediate", 8'h5a, u_mem.mem[16'h0080])
    exec(32'h4e80_819d, 5);
    `CHK("move direct", 8'h5a, u_mem.mem[16'h0081])
    exec(32'h5e81_9d9d, 4);
    `CHK("move to index", {8'h5a, 16'h01e4}, {u_mem.mem[16'h01e3], regs.hx})
    exec(32'h7e82_9d9d, 4);
    `CHK("move from index", {8'h55, 16'h01e5}, {u_mem.mem[16'h0082], regs.hx})
  endtask

  // Bit test and branch with a backward and a forward displacement.
  task automatic s_branch();
    logic [15:0] p;
    p = regs.pc;
    exec(32'h0280_fd9d, 4);
    `CHK("branch if set", {p, 1'b1}, {regs.pc, regs.flg[0]})
    exec(32'h0180_029d, 4);
    `CHK("branch if clear", {p + 16'h0005, 1'b0}, {regs.pc, regs.flg[0]})
  endtask

  // Software trap stacks the context and vectors.
  task automatic s_trap();
    logic [15:0] q;
    q = regs.pc + 16'h0001;
    u_mem.mem[16'hfff0] = 8'h20;
    u_mem.mem[16'hfff1] = 8'h00;
    exec(32'h839d_9d9d, 9);
    `CHK("pushed return", {q[7:0], q[15:8]}, {u_mem.mem[16'h01e0], u_mem.mem[16'h01df]})
    `CHK("push xac", 24'he5_1460, {u_mem.mem[16'h01de], u_mem.mem[16'h01dd], u_mem.mem[16'h01dc]})
    `CHK("trap regs", {16'h2000, 16'h01db, 8'h68}, {regs.pc, regs.sp, regs.flg})
  endtask

  // Wait halts until the interrupt pin is seen, with the mask cleared.
  task automatic s_wait();
    exec(32'h8f9d_9d9d, 1);
    `CHK("halt flags", {1'b1, 8'h60}, {core_halted, regs.flg})
    repeat (5) @(negedge clk_sys);
    `CHK("still halted", 1'b1, core_halted)
    irq_req = 1'b1;
    for (int i = 0; i < 8 && core_halted === 1'b1; i++) @(negedge clk_sys);
    irq_req = 1'b0;
    if (core_halted !== 1'b0) begin
      fail_count++;
      report_and_stop();
    end
    `CHK("wake pc", 16'h2001, regs.pc)
  endtask

  // Main sequence: reset for 12 cycles, then the scenarios in order.
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    irq_req = 1'b0;
    fail_count = 0;
    n_tests = 0;
    for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'h9d;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    s_xfer();
    s_test();
    s_modes();
    s_move();
    s_branch();
    s_trap();
    s_wait();
    report_and_stop();
  end
endmodule // tb_cpu_insn_decode_tail
